// [rtl/codec_host_end.sv]
// Host end: APB command registers driving the codec control link
`timescale 1ns/10ps
`default_nettype none
module codec_host_end
  import codec_pkg::*;
(
  input  wire logic        pclk,    // System clock
  input  wire logic        presetn, // Async reset, active low
  ctl_link_if.host         link,    // Control link to device
  input  wire logic        psel,    // APB select
  input  wire logic        penable, // APB enable
  input  wire logic        pwrite,  // APB write
  input  wire logic [11:0] paddr,   // APB byte address
  input  wire logic [31:0] pwdata,  // APB write data
  output logic      [31:0] prdata,  // APB read data
  output logic             pready,  // APB ready, always high
  output logic             pslverr  // APB error
);
  typedef enum logic [2:0] {
    H_IDLE  = 3'h1,
    H_ISSUE = 3'h2,
    H_WAIT  = 3'h4
  } host_state_t;

  host_state_t st_q, st_d;
  logic [7:0]  addr_q, addr_d, data_q, data_d, rd_q, rd_d;
  logic        isrd_q, isrd_d, pin_q, pin_d;
  logic        acc, cmd_wr, mapped;

  assign acc    = psel & penable;
  assign cmd_wr = acc & pwrite & (paddr == HOST_CMD);
  assign mapped = (paddr == HOST_CMD) || (paddr == HOST_STAT) ||
                  (paddr == HOST_PIN);

  // Command sequencing; software orders calibration, clock and power steps
  always_comb begin
    st_d   = st_q;
    addr_d = addr_q;
    data_d = data_q;
    isrd_d = isrd_q;
    rd_d   = rd_q;
    pin_d  = pin_q;
    if (acc && pwrite && paddr == HOST_PIN) pin_d = pwdata[0];
    unique case (st_q)
      H_IDLE: begin
        // host forwards each step in order
        if (cmd_wr) begin
          addr_d = pwdata[CMD_ADDR_LSB +: 8];
          data_d = pwdata[7:0];
          isrd_d = pwdata[CMD_RD_BIT];
          st_d   = H_ISSUE;
        end
      end
      H_ISSUE: st_d = isrd_q ? H_WAIT : H_IDLE;
      H_WAIT: begin
        rd_d = link.rdata;
        st_d = H_IDLE;
      end
      default: st_d = H_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q   <= H_IDLE;
      addr_q <= 8'h00;
      data_q <= 8'h00;
      isrd_q <= 1'b0;
      rd_q   <= 8'h00;
      pin_q  <= 1'b1;
    end else begin
      st_q   <= st_d;
      addr_q <= addr_d;
      data_q <= data_d;
      isrd_q <= isrd_d;
      rd_q   <= rd_d;
      pin_q  <= pin_d;
    end
  end

  // address and data held static between commands
  assign link.addr       = addr_q;
  assign link.wdata      = data_q;
  assign link.wr         = (st_q == H_ISSUE) & ~isrd_q;
  assign link.rd         = (st_q == H_ISSUE) & isrd_q;
  assign link.select_pin = pin_q;

  // APB answers with zero wait; busy command writes are refused
  assign pready  = 1'b1;
  assign pslverr = acc & (~mapped | (cmd_wr & (st_q != H_IDLE)));
  assign prdata  = (paddr == HOST_STAT) ?
                     {22'h0, pin_q, (st_q != H_IDLE), rd_q} :
                   (paddr == HOST_CMD) ?
                     {15'h0, isrd_q, addr_q, data_q} :
                   (paddr == HOST_PIN) ? {31'h0, pin_q} : 32'h0;
endmodule
`default_nettype wire

// [rtl/codec_path_control.sv]
// Codec path control device: registers, DC removal, power sequencing, mute
//
// Summary of operation
// - Subtract running DC estimate while filter active
// - Hold bit freezes estimate, still subtracted
// - Host calibrates: settle filter, then freeze
// - Selector routes one of six input pairs
// - Gain from -12 to +12 dB, half-dB
// - Only pair four has optional mic boost
// - Reset defaults: line input one, unity gain
// - Power-up ramp 200 ms, audio after 2000 frames
// - Outputs clamped low until power-down cleared
// - Host powers down 250 ms before removal
// - Host sends zeros ten frames before clock change
// - Zero DAC output during clocking change
// - Aux source: ADC input, DAC, or high-impedance
// - De-emphasis only in single-speed mode
// - Loopback routes ADC data to DAC
// - Format field ignored while loopback set
// - Serial output keeps ADC data and format
// - Mute asserted in listed conditions
// - Mute output push-pull, active low
// - Control accepted anytime; host pins static idle
// - Falling select edge after reset selects SPI
// - Otherwise I2C, strap gives address bit
// - Power-down set after reset, writes accepted
`timescale 1ns/10ps
`default_nettype none
module codec_path_control
  import codec_pkg::*;
#(
  parameter int RAMP_CYCLES = RAMP_CYC
) (
  input  wire logic        pclk,           // System clock
  input  wire logic        presetn,        // Async reset, active low
  ctl_link_if.dev          link,           // Control link from host
  input  wire logic        frame_sync,     // Frame sync pin
  input  wire logic        ratio_ok,       // Clock ratio valid pin
  input  wire logic        adc_valid,      // Decimator sample strobe
  input  wire logic [15:0] adc_left,       // Decimator left sample
  input  wire logic [15:0] adc_right,      // Decimator right sample
  input  wire logic        din_valid,      // Serial input sample strobe
  input  wire logic [15:0] din_left,       // Serial input left
  input  wire logic [15:0] din_right,      // Serial input right
  output logic             dac_valid,      // DAC sample strobe
  output logic      [15:0] dac_out_left,   // DAC left data
  output logic      [15:0] dac_out_right,  // DAC right data
  output logic      [1:0]  dac_format,     // Effective DAC format
  output logic             serial_audio_out_valid,    // Serial output strobe
  output logic      [15:0] serial_audio_out_left,     // Serial output left
  output logic      [15:0] serial_audio_out_right,    // Serial output right
  output logic             serial_audio_out_format,   // ADC format in use
  output logic             clamp_low,      // Outputs held to low reference
  output logic             ramp_active,    // Reference ramp running
  output logic      [5:0]  input_pair_sel, // One-hot input pair
  output logic             mic_boost_en,   // Boost on pair four
  output logic      [5:0]  left_gain,      // Left gain, half-dB steps
  output logic      [5:0]  right_gain,     // Right gain, half-dB steps
  output logic      [1:0]  aux_source,     // 0 ADC, 1 DAC, else hi-Z
  output logic             deemph_on,      // De-emphasis applied
  output logic             mute_ctrl_out,  // External mute, active low
  output logic             spi_mode,       // Control port in SPI mode
  output logic             addr_lsb        // I2C low address bit
);
  typedef enum logic [2:0] {
    ST_PDOWN = 3'h1,
    ST_RAMP  = 3'h2,
    ST_RUN   = 3'h4
  } pwr_state_t;

  logic [7:0]  pwr_q, dac_q, adc_q, sig_q, lg_q, rg_q, ins_q, rdata_q;
  logic [7:0]  pwr_d, dac_d, adc_d, sig_d, lg_d, rg_d, ins_d, rdata_d;
  logic [1:0]  fmt_q, fmt_d;
  logic [0:0]  sel_s1_q, sel_s2_q, fs_s1_q, fs_s2_q, ok_s1_q, ok_s2_q;
  logic        fs_last_q, fs_tick;
  logic [1:0]  seen_q, seen_d;
  logic        spi_q, spi_d, strap_q, strap_d;
  logic        sel_last_q, sel_last_d;
  pwr_state_t  st_q, st_d;
  logic [31:0] ramp_q, ramp_d;
  logic [10:0] warm_q, warm_d;
  logic [3:0]  chg_q, chg_d;
  logic [15:0] est_l_q, est_l_d, est_r_q, est_r_d;
  logic [15:0] dl_q, dl_d, dr_q, dr_d, sl_q, sl_d, sr_q, sr_d;
  logic        dv_q, dv_d, sv_q, sv_d, mute_q, mute_d;
  logic        loop, zero_dac, power_down_bit;

  // Signed clamp of a gain code to the legal range
  function automatic logic [5:0] clamp_gain(input logic [7:0] v);
    logic signed [7:0] s;
    s = {{2{v[5]}}, v[5:0]}; // Code lives in the low six bits
    if (s > $signed({2'h0, GAIN_MAX})) clamp_gain = GAIN_MAX;
    else if (s < $signed({2'h3, GAIN_MIN})) clamp_gain = GAIN_MIN;
    else clamp_gain = v[5:0];
  endfunction

  // One filter step: move estimate a fraction toward the sample
  function automatic logic [15:0] est_step(input logic [15:0] x,
                                           input logic [15:0] e);
    logic signed [16:0] diff;
    diff = $signed({x[15], x}) - $signed({e[15], e});
    est_step = e + 16'(diff >>> HPF_SHIFT);
  endfunction

  // Pin inputs pass two flops before use; only the second is read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_s1_q  <= 1'b0;
      sel_s2_q  <= 1'b0;
      fs_s1_q   <= 1'b0;
      fs_s2_q   <= 1'b0;
      ok_s1_q   <= 1'b0;
      ok_s2_q   <= 1'b0;
      fs_last_q <= 1'b0;
    end else begin
      sel_s1_q  <= link.select_pin;
      sel_s2_q  <= sel_s1_q;
      fs_s1_q   <= frame_sync;
      fs_s2_q   <= fs_s1_q;
      ok_s1_q   <= ratio_ok;
      ok_s2_q   <= ok_s1_q;
      fs_last_q <= fs_s2_q[0];
    end
  end
  assign fs_tick = fs_s2_q[0] & ~fs_last_q;

  assign loop = sig_q[SIG_LOOP_BIT];
  assign power_down_bit  = pwr_q[PWR_PDN_BIT];

  // Register file; writes accepted in every power state
  always_comb begin
    pwr_d = pwr_q;
    dac_d = dac_q;
    adc_d = adc_q;
    sig_d = sig_q;
    lg_d  = lg_q;
    rg_d  = rg_q;
    ins_d = ins_q;
    chg_d = chg_q;
    if (chg_q != 4'h0 && fs_tick) chg_d = chg_q - 4'h1;
    if (link.wr) begin
      unique case (link.addr)
        REG_POWER:  pwr_d = link.wdata;
        REG_DAC: begin
          dac_d = link.wdata;
          if (link.wdata[DAC_SPEED_LSB +: 2] != dac_q[DAC_SPEED_LSB +: 2])
            chg_d = CHG_FRAMES;
        end
        REG_ADC:    adc_d = link.wdata;
        REG_SIGSEL: sig_d = link.wdata;
        REG_LGAIN:  lg_d  = link.wdata;
        REG_RGAIN:  rg_d  = link.wdata;
        REG_INSEL:  ins_d = link.wdata;
        default: ;
      endcase
    end
    rdata_d = rdata_q;
    if (link.rd) begin
      unique case (link.addr)
        REG_POWER:  rdata_d = pwr_q;
        REG_DAC:    rdata_d = dac_q;
        REG_ADC:    rdata_d = adc_q;
        REG_SIGSEL: rdata_d = sig_q;
        REG_LGAIN:  rdata_d = lg_q;
        REG_RGAIN:  rdata_d = rg_q;
        REG_INSEL:  rdata_d = ins_q;
        default:    rdata_d = 8'h00;
      endcase
    end
    fmt_d = loop ? fmt_q : dac_q[DAC_FMT_LSB +: 2];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_q   <= POWER_RST;
      dac_q   <= DAC_RST;
      adc_q   <= ADC_RST;
      sig_q   <= SIGSEL_RST;
      lg_q    <= GAIN_RST;
      rg_q    <= GAIN_RST;
      ins_q   <= INSEL_RST;
      rdata_q <= 8'h00;
      fmt_q   <= DAC_RST[DAC_FMT_LSB +: 2];
      chg_q   <= 4'h0;
    end else begin
      pwr_q   <= pwr_d;
      dac_q   <= dac_d;
      adc_q   <= adc_d;
      sig_q   <= sig_d;
      lg_q    <= lg_d;
      rg_q    <= rg_d;
      ins_q   <= ins_d;
      rdata_q <= rdata_d;
      fmt_q   <= fmt_d;
      chg_q   <= chg_d;
    end
  end

  // Control mode detect; strap waits until both sync stages hold the pin,
  // since the reset value of the synchroniser says nothing about the strap
  always_comb begin
    seen_d     = (seen_q == 2'h3) ? seen_q : seen_q + 2'h1;
    strap_d    = (seen_q == 2'h2) ? sel_s2_q[0] : strap_q;
    sel_last_d = sel_s2_q[0];
    spi_d      = spi_q;
    if (seen_q == 2'h3 && sel_last_q && !sel_s2_q[0]) spi_d = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_q     <= 2'h0;
      strap_q    <= 1'b0;
      sel_last_q <= 1'b0;
      spi_q      <= 1'b0;
    end else begin
      seen_q     <= seen_d;
      strap_q    <= strap_d;
      sel_last_q <= sel_last_d;
      spi_q      <= spi_d;
    end
  end

  // Power sequence; ramp counts cycles, warm-up counts frames together
  always_comb begin
    st_d   = st_q;
    ramp_d = ramp_q;
    warm_d = warm_q;
    unique case (st_q)
      ST_PDOWN: begin
        ramp_d = 32'h0;
        warm_d = 11'h0;
        if (!power_down_bit) st_d = ST_RAMP;
      end
      ST_RAMP: begin
        if (ramp_q < 32'(RAMP_CYCLES)) ramp_d = ramp_q + 32'h1;
        if (warm_q < WARM_FRAMES && fs_tick) warm_d = warm_q + 11'h1;
        if (ramp_q >= 32'(RAMP_CYCLES) && warm_q >= WARM_FRAMES)
          st_d = ST_RUN;
      end
      ST_RUN: ;
      default: st_d = ST_PDOWN;
    endcase
    if (power_down_bit) st_d = ST_PDOWN;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q   <= ST_PDOWN;
      ramp_q <= 32'h0;
      warm_q <= 11'h0;
    end else begin
      st_q   <= st_d;
      ramp_q <= ramp_d;
      warm_q <= warm_d;
    end
  end

  assign zero_dac = (chg_q != 4'h0) || (st_q != ST_RUN);

  // DC removal, DAC source selection and output data
  always_comb begin
    est_l_d = est_l_q;
    est_r_d = est_r_q;
    sl_d    = sl_q;
    sr_d    = sr_q;
    sv_d    = 1'b0;
    dl_d    = dl_q;
    dr_d    = dr_q;
    dv_d    = 1'b0;
    if (adc_valid) begin
      if (adc_q[ADC_HPF_BIT] && !adc_q[ADC_HOLD_BIT]) begin
        est_l_d = est_step(adc_left, est_l_q);
        est_r_d = est_step(adc_right, est_r_q);
      end
      // subtract estimate; output continues in loopback
      sl_d = adc_left - est_l_q;
      sr_d = adc_right - est_r_q;
      sv_d = 1'b1;
    end
    if (loop ? adc_valid : din_valid) begin
      dl_d = loop ? adc_left - est_l_q : din_left;
      dr_d = loop ? adc_right - est_r_q : din_right;
      dv_d = 1'b1;
      if (zero_dac) begin
        dl_d = 16'h0000;
        dr_d = 16'h0000;
      end
    end
    mute_d = power_down_bit || (st_q != ST_RUN) || dac_q[DAC_MUTE_BIT] || !ok_s2_q[0];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      est_l_q <= 16'h0000;
      est_r_q <= 16'h0000;
      sl_q    <= 16'h0000;
      sr_q    <= 16'h0000;
      sv_q    <= 1'b0;
      dl_q    <= 16'h0000;
      dr_q    <= 16'h0000;
      dv_q    <= 1'b0;
      mute_q  <= 1'b1;
    end else begin
      est_l_q <= est_l_d;
      est_r_q <= est_r_d;
      sl_q    <= sl_d;
      sr_q    <= sr_d;
      sv_q    <= sv_d;
      dl_q    <= dl_d;
      dr_q    <= dr_d;
      dv_q    <= dv_d;
      mute_q  <= mute_d;
    end
  end

  // Outputs; mute pin is low in reset since mute_q resets high
  assign link.rdata    = rdata_q;
  assign dac_valid     = dv_q;
  assign dac_out_left  = dl_q;
  assign dac_out_right = dr_q;
  assign dac_format    = fmt_q;
  assign serial_audio_out_valid   = sv_q;
  assign serial_audio_out_left    = sl_q;
  assign serial_audio_out_right   = sr_q;
  assign serial_audio_out_format  = adc_q[ADC_FMT_BIT];
  assign clamp_low     = (st_q == ST_PDOWN);
  assign ramp_active   = (st_q == ST_RAMP);
  // one of six pairs; boost only on pair four
  assign input_pair_sel = (ins_q[2:0] == INSEL_MIC) ? 6'h08 :
                          (ins_q[2:0] > 3'h5) ? 6'h01 :
                          6'(6'h01 << ins_q[2:0]);
  assign mic_boost_en  = (ins_q[2:0] == INSEL_MIC);
  assign left_gain     = clamp_gain(lg_q);
  assign right_gain    = clamp_gain(rg_q);
  assign aux_source    = sig_q[SIG_AUX_LSB +: 2];
  assign deemph_on     = dac_q[DAC_DEEMPH_BIT] &&
                         (dac_q[DAC_SPEED_LSB +: 2] == SPEED_SINGLE);
  assign mute_ctrl_out = ~mute_q;
  assign spi_mode      = spi_q;
  assign addr_lsb      = strap_q;
endmodule
`default_nettype wire

// [shared/codec_pkg.sv]
// Shared constants for the codec path control device and its host end
package codec_pkg;
  // Device register offsets on the control link
  localparam logic [7:0] REG_POWER  = 8'h02;
  localparam logic [7:0] REG_DAC    = 8'h03;
  localparam logic [7:0] REG_ADC    = 8'h04;
  localparam logic [7:0] REG_SIGSEL = 8'h06;
  localparam logic [7:0] REG_LGAIN  = 8'h07;
  localparam logic [7:0] REG_RGAIN  = 8'h08;
  localparam logic [7:0] REG_INSEL  = 8'h09;
  // Field positions
  localparam int PWR_PDN_BIT    = 0;
  localparam int DAC_SPEED_LSB  = 6;
  localparam int DAC_FMT_LSB    = 4;
  localparam int DAC_MUTE_BIT   = 2;
  localparam int DAC_DEEMPH_BIT = 1;
  localparam int ADC_FMT_BIT    = 4;
  localparam int ADC_HOLD_BIT   = 1;
  localparam int ADC_HPF_BIT    = 0;
  localparam int SIG_AUX_LSB    = 5;
  localparam int SIG_LOOP_BIT   = 1;
  // Reset values
  localparam logic [7:0] POWER_RST  = 8'h01;
  localparam logic [7:0] DAC_RST    = 8'h00;
  localparam logic [7:0] ADC_RST    = 8'h01;
  localparam logic [7:0] SIGSEL_RST = 8'h00;
  localparam logic [7:0] GAIN_RST   = 8'h00;
  localparam logic [7:0] INSEL_RST  = 8'h00;
  // Encodings
  localparam logic [1:0] SPEED_SINGLE = 2'h0;
  localparam logic [1:0] AUX_ADC      = 2'h0;
  localparam logic [1:0] AUX_DAC      = 2'h1;
  localparam logic [2:0] INSEL_MIC    = 3'h6;
  localparam logic [2:0] INSEL_PAIR4  = 3'h3;
  localparam logic [5:0] GAIN_MAX     = 6'h18;
  localparam logic [5:0] GAIN_MIN     = 6'h28;
  // Timing
  localparam int CLK_HZ      = 100_000_000;
  localparam int RAMP_MS     = 200;
  localparam int RAMP_CYC    = (CLK_HZ / 1000) * RAMP_MS;
  localparam logic [10:0] WARM_FRAMES = 11'h7D0;
  localparam logic [3:0]  CHG_FRAMES  = 4'hA;
  localparam int HPF_SHIFT   = 8;
  // Host register offsets and command fields
  localparam logic [11:0] HOST_CMD  = 12'h000;
  localparam logic [11:0] HOST_STAT = 12'h004;
  localparam logic [11:0] HOST_PIN  = 12'h008;
  localparam int CMD_RD_BIT   = 16;
  localparam int CMD_ADDR_LSB = 8;
endpackage

// [shared/ctl_link_if.sv]
// Control link between the host end and the codec path control device
`timescale 1ns/10ps
`default_nettype none
interface ctl_link_if;
  logic       select_pin; // Shared address or chip-select pin level
  logic       wr;         // One-cycle register write
  logic       rd;         // One-cycle register read
  logic [7:0] addr;       // Register offset
  logic [7:0] wdata;      // Write data
  logic [7:0] rdata;      // Read data, valid the cycle after rd
  modport dev  (input select_pin, wr, rd, addr, wdata, output rdata);
  modport host (output select_pin, wr, rd, addr, wdata, input rdata);
endinterface
`default_nettype wire

// [verif/codec_link_chk.sv]
// Assertions on the control link and the device status outputs
`timescale 1ns/10ps
`default_nettype none
module codec_link_chk (
  input wire logic       pclk,           // Clock
  input wire logic       presetn,        // Reset, active low
  input wire logic       wr,             // Link write
  input wire logic       rd,             // Link read
  input wire logic [7:0] rdata,          // Link read data
  input wire logic       ratio_ok,       // Ratio valid pin
  input wire logic       clamp_low,      // Output clamp
  input wire logic       ramp_active,    // Ramp running
  input wire logic       mute_ctrl_out,  // Mute, active low
  input wire logic [5:0] input_pair_sel, // One-hot pair
  input wire logic       mic_boost_en,   // Boost enable
  input wire logic [5:0] left_gain,      // Left gain code
  input wire logic       spi_mode        // SPI selected
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_wr_single: assert property (wr |=> !wr)
    else $error("link write longer than one cycle");
  a_no_overlap: assert property (!(wr && rd))
    else $error("link read and write together");
  a_rdata_hold: assert property (!rd |=> $stable(rdata))
    else $error("read data moved without a read");
  a_clamp_mute: assert property (
    clamp_low && $past(clamp_low) |-> !mute_ctrl_out)
    else $error("mute released while clamped");
  a_ramp_mute: assert property (ramp_active |-> !mute_ctrl_out)
    else $error("mute released during ramp");
  // Two sync stages plus the output register
  a_ratio_mute: assert property (!ratio_ok [*4] |-> !mute_ctrl_out)
    else $error("mute released with bad ratio");
  a_unmute_clear: assert property (
    $rose(mute_ctrl_out) |-> !clamp_low && !ramp_active)
    else $error("mute released too early");
  a_pair_onehot: assert property ($onehot(input_pair_sel))
    else $error("input pair select not one-hot");
  a_boost_pair: assert property (
    mic_boost_en |-> input_pair_sel == 6'h08)
    else $error("boost outside pair four");
  a_gain_span: assert property (
    $signed(left_gain) <= 24 && $signed(left_gain) >= -24)
    else $error("gain code out of span");
  a_ramp_start: assert property ($fell(clamp_low) |-> ramp_active)
    else $error("clamp released without ramp");
  a_spi_sticky: assert property (spi_mode |=> spi_mode)
    else $error("control mode left SPI");

  c_powerup: cover property ($fell(clamp_low));
  c_unmute: cover property ($rose(mute_ctrl_out));
  c_spi: cover property ($rose(spi_mode));
  c_boost: cover property (mic_boost_en);
endmodule
`default_nettype wire

// [verif/tb.sv]
// Self-checking bench joining the host end and the codec device
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin \
  tests_run++; \
  if ((g) !== (e)) begin \
    n_mismatch++; \
    $display("mismatch %s exp %0h got %0h", nm, e, g); \
  end \
end
module tb;
  import codec_pkg::*;
  localparam int RAMP = 50; // Short reference ramp keeps the run brief
  localparam logic [7:0] RA [7] = '{REG_POWER, REG_DAC, REG_ADC,
    REG_SIGSEL, REG_LGAIN, REG_RGAIN, REG_INSEL};
  localparam logic [7:0] RV [7] = '{POWER_RST, DAC_RST, ADC_RST,
    SIGSEL_RST, GAIN_RST, GAIN_RST, INSEL_RST};
  localparam logic [7:0] GC [5] = '{8'h18, 8'h19, 8'h28, 8'h27, 8'h20};
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd_q;
  logic        pready, pslverr, err;
  logic [1:0]  fs_q = 2'h0;
  logic        frame_sync = 1'b0, ratio_ok = 1'b1;
  logic        adc_valid = 1'b0, din_valid = 1'b0;
  logic [15:0] adc_left = 16'h0, adc_right = 16'h0;
  logic [15:0] din_left = 16'h0, din_right = 16'h0;
  logic [15:0] dac_out_left, dac_out_right, serial_audio_out_left, serial_audio_out_right;
  logic [15:0] v, a0, est;
  logic [7:0]  b, g;
  logic        dac_valid, serial_audio_out_valid, serial_audio_out_format, clamp_low;
  logic        ramp_active, mic_boost_en, deemph_on, mute_ctrl_out;
  logic        spi_mode, addr_lsb;
  logic [1:0]  dac_format, aux_source;
  logic [5:0]  input_pair_sel, left_gain, right_gain;
  int          n_mismatch = 0, tests_run = 0, n;

  ctl_link_if link ();
  codec_path_control #(.RAMP_CYCLES(RAMP)) i_codec_path_control (
    .pclk, .presetn, .link(link), .frame_sync, .ratio_ok, .adc_valid,
    .adc_left, .adc_right, .din_valid, .din_left, .din_right, .dac_valid,
    .dac_out_left, .dac_out_right, .dac_format, .serial_audio_out_valid, .serial_audio_out_left,
    .serial_audio_out_right, .serial_audio_out_format, .clamp_low, .ramp_active, .input_pair_sel,
    .mic_boost_en, .left_gain, .right_gain, .aux_source, .deemph_on,
    .mute_ctrl_out, .spi_mode, .addr_lsb);
  codec_host_end i_codec_host_end (.pclk, .presetn, .link(link), .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  codec_link_chk i_chk (.pclk, .presetn, .wr(link.wr), .rd(link.rd),
    .rdata(link.rdata), .ratio_ok, .clamp_low, .ramp_active, .mute_ctrl_out,
    .input_pair_sel, .mic_boost_en, .left_gain, .spi_mode);

  // Clock and a four-cycle frame so warm-up stays short
  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    fs_q <= fs_q + 2'h1;
    frame_sync <= fs_q[1];
  end

  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // APB transfer: request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 100);
    if (pready !== 1'b1) n_mismatch++; // A wait that runs out fails
    rd_q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Device access through the command word; busy lasts one cycle for a write, two for a read
  task automatic dev_wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, HOST_CMD, {16'h0000, a, d});
    repeat (3) @(posedge pclk);
  endtask
  task automatic dev_rd(input logic [7:0] a, output logic [7:0] d);
    apb(1'b1, HOST_CMD, {15'h0000, 1'b1, a, 8'h00});
    repeat (4) @(posedge pclk);
    apb(1'b0, HOST_STAT, 32'h0);
    d = rd_q[7:0];
  endtask

  // One sample on the converter side or the serial input
  task automatic smp(input logic ad, input logic [15:0] x);
    @(posedge pclk);
    adc_valid <= ad;
    din_valid <= !ad;
    adc_left <= x;
    adc_right <= x;
    din_left <= x;
    din_right <= x;
    @(posedge pclk);
    adc_valid <= 1'b0;
    din_valid <= 1'b0;
    @(posedge pclk);
  endtask

  function automatic logic [5:0] pair_exp(input int c);
    if (c < 6) return 6'h01 << c;
    return (c == 6) ? 6'h08 : 6'h01;
  endfunction
  // Gain codes saturate at twelve dB either way
  function automatic logic [5:0] gain_exp(input logic [7:0] x);
    logic signed [5:0] s;
    s = x[5:0];
    if (s > 24) return 6'h18;
    if (s < -24) return 6'h28;
    return x[5:0];
  endfunction

  initial begin
    repeat (60000) @(posedge pclk);
    n_mismatch++;
    results();
  end

  initial begin
    void'($urandom(58978));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      dev_rd(RA[i], b);
      `CHK("reset value", RV[i], b)
    end
    `CHK("clamp", 1'b1, clamp_low)
    `CHK("mute", 1'b0, mute_ctrl_out)
    `CHK("pair", 6'h01, input_pair_sel)
    `CHK("gain", 6'h00, left_gain)
    `CHK("addr bit", 1'b1, addr_lsb)
    apb(1'b0, 12'hFFC, 32'h0);
    `CHK("apb error", 1'b1, err)
    dev_rd(8'h55, b);
    `CHK("unmapped", 8'h00, b)
    for (int c = 0; c < 8; c++) begin
      dev_wr(REG_INSEL, 8'(c));
      `CHK("pair", pair_exp(c), input_pair_sel)
      `CHK("boost", c == 6, mic_boost_en)
    end
    for (int i = 0; i < 11; i++) begin
      g = (i < 5) ? GC[i] : 8'($urandom);
      dev_wr(REG_LGAIN, g);
      dev_wr(REG_RGAIN, ~g);
      `CHK("left gain", gain_exp(g), left_gain)
      `CHK("right gain", gain_exp(~g), right_gain)
    end
    dev_rd(REG_LGAIN, b);
    `CHK("readback", g, b)
    for (int c = 0; c < 4; c++) begin
      dev_wr(REG_SIGSEL, 8'(c << 5));
      `CHK("aux", 2'(c), aux_source)
      dev_wr(REG_DAC, 8'(c << 6) | 8'h02);
      `CHK("deemph", c == 0, deemph_on)
    end
    dev_wr(REG_DAC, 8'h00);
    dev_wr(REG_POWER, 8'h00);
    `CHK("clamp", 1'b0, clamp_low)
    repeat (1000) @(posedge pclk);
    `CHK("ramp", 1'b1, ramp_active)
    n = 0;
    while (ramp_active !== 1'b0 && n < 20000) begin
      @(posedge pclk);
      n++;
    end
    `CHK("ramp length", 1'b1, n > 6500 && n < 20000)
    repeat (3) @(posedge pclk);
    `CHK("mute", 1'b1, mute_ctrl_out)
    ratio_ok <= 1'b0;
    repeat (5) @(posedge pclk);
    `CHK("mute", 1'b0, mute_ctrl_out)
    ratio_ok <= 1'b1;
    dev_wr(REG_DAC, 8'h04);
    `CHK("mute", 1'b0, mute_ctrl_out)
    dev_wr(REG_DAC, 8'h00);
    `CHK("mute", 1'b1, mute_ctrl_out)
    v = 16'($urandom) | 16'h0001;
    smp(1'b0, v);
    `CHK("dac data", v, dac_out_left)
    `CHK("dac right", v, dac_out_right)
    repeat (14) smp(1'b0, 16'h0000);
    dev_wr(REG_DAC, 8'h40);
    smp(1'b0, v);
    `CHK("dac zero", 16'h0000, dac_out_left)
    repeat (100) @(posedge pclk);
    smp(1'b1, 16'h1000);
    a0 = serial_audio_out_left;
    repeat (200) smp(1'b1, 16'h1000);
    `CHK("dc removal", 1'b1, $signed(serial_audio_out_left) < $signed(a0))
    dev_wr(REG_ADC, 8'h12);
    v = 16'($urandom) & 16'h3FFF;
    smp(1'b1, v);
    a0 = serial_audio_out_left;
    est = v - a0;
    smp(1'b1, v + 16'h0005);
    `CHK("frozen", 16'h0005, serial_audio_out_left - a0)
    dev_wr(REG_SIGSEL, 8'h02);
    dev_wr(REG_DAC, 8'h60);
    `CHK("dac format", 2'h0, dac_format)
    v = 16'($urandom) & 16'h3FFF;
    smp(1'b1, v);
    `CHK("loop valid", 1'b1, dac_valid)
    `CHK("loop data", v - est, dac_out_left)
    `CHK("loop right", v - est, dac_out_right)
    `CHK("serial out", v - est, serial_audio_out_left)
    `CHK("serial right", v - est, serial_audio_out_right)
    `CHK("serial valid", 1'b1, serial_audio_out_valid)
    `CHK("adc format", 1'b1, serial_audio_out_format)
    dev_wr(REG_SIGSEL, 8'h00);
    `CHK("dac format", 2'h2, dac_format)
    `CHK("i2c mode", 1'b0, spi_mode)
    apb(1'b1, HOST_PIN, 32'h0);
    repeat (6) @(posedge pclk);
    `CHK("spi mode", 1'b1, spi_mode)
    `CHK("addr bit", 1'b1, addr_lsb)
    dev_wr(REG_POWER, 8'h01);
    `CHK("clamp", 1'b1, clamp_low)
    `CHK("mute", 1'b0, mute_ctrl_out)
    results();
  end
endmodule
`default_nettype wire
